// file: common/charger_flag_consts.svh
`ifndef CHARGER_FLAG_CONSTS_SVH
`define CHARGER_FLAG_CONSTS_SVH

// interrupt pulse width and its cycle count at 25 MHz (40 ns period)
`define INT_PULSE_NS 128000
`define CLK_PERIOD_NS 40
`define INT_PULSE_CYC (`INT_PULSE_NS / `CLK_PERIOD_NS)
`define INT_CNT_W 12

// flag positions inside the flag vector
`define FLAG_PGOOD 0
`define FLAG_OVP 1
`define FLAG_OCP 2
`define FLAG_COLD 3
`define FLAG_DONE 4
`define FLAG_ILIM 5
`define FLAG_DPPM 6
`define FLAG_VINDPM 7
`define FLAG_THERM 8
`define NUM_FLAGS 9

// system rail mode encodings
`define RAIL_MODE_NORMAL 2'h0

// cycles the condition synchroniser needs after reset before its output is real
`define SYNC_FILL 2'h3

// control outputs in reset: charging off, safety timer held cleared
`define CTRL_RESET 8'h20

`endif

// file: common/charger_flag_pkg.sv
`default_nettype none

package charger_flag_pkg;

  typedef logic [8:0] flag_vec_t;

  typedef struct packed {
    logic pgood;
    logic ovp;
    logic ocp;
    logic cold;
    logic done;
    logic ilim;
    logic dppm;
    logic vindpm;
    logic therm;
    logic bat_uvlo;
    logic recharge;
    logic ce;
  } cond_s;

  typedef struct packed {
    logic charge_en;
    logic reduced_current;
    logic timer_reset;
    logic timer_pause;
    logic timer_double;
    logic rail_from_input;
    logic rail_from_battery;
    logic battery_disconnect;
  } ctrl_s;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b10
  } start_e;

endpackage : charger_flag_pkg

`default_nettype wire

// file: rtl/charger_fault_flag_response.sv
// Contract
// R1 - power-good flag on both edges; low status disables charging and resets timer
// R2 - no power-good interrupt when starting good with battery under lockout
// R3 - rail fed from input only with power good and rail mode 00
// R4 - overvoltage: flag, pause charging, reset timer, rail from battery
// R5 - overcurrent: flag, charging disabled, battery disconnected from rail
// R6 - cold: flag, pause charging, timer paused while cold
// R7 - done: flag, pause, reset timer; resume on input, enable toggle or recharge
// R8 - current limit: flag, reduced current, optional doubled timer, rail from input
// R9 - loop flags set on activation; reduced current, optional doubled timer
// R10 - interrupt drives open-drain line low for a 128 us pulse
// R11 - masked events give no pulse; unmasking needs a new trigger
// R12 - interrupts only after valid start-up; fault start sends none
// R13 - flags latch until host read clears them
`timescale 1ns/100ps
`default_nettype none
`include "charger_flag_consts.svh"

module charger_fault_flag_response
  import charger_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire charger_flag_pkg::cond_s cond_i,
  input wire logic [1:0] system_rail_mode_i,
  input wire logic timer_double_en_i,
  input wire charger_flag_pkg::flag_vec_t int_mask_i,
  input wire logic flag_read_i,
  output charger_flag_pkg::flag_vec_t flags_o,
  output charger_flag_pkg::ctrl_s ctrl_o,
  output logic int_n_o,
  output logic int_oe_o
);
  import charger_flag_pkg::*;

  typedef struct packed {
    cond_s s1;
    cond_s s2;
    cond_s s3;
    cond_s stable;
    flag_vec_t flags;
    start_e start;
    logic [1:0] fill;
    logic pg_suppress;
    logic done_hold;
    logic [1:0] rail_mode;
    logic dbl_en;
    ctrl_s ctrl;
  } core_s;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  core_s state_ff;
  core_s nxt_state;
  flag_vec_t trig;
  flag_vec_t fire_vec;
  logic fire;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  function automatic flag_vec_t level_vec(input cond_s c);
    level_vec = {c.therm, c.vindpm, c.dppm, c.ilim, c.done, c.cold, c.ocp, c.ovp, c.pgood};
  endfunction

  always_comb
  begin
    cond_s nxt_stable;
    flag_vec_t cur;
    flag_vec_t prv;
    nxt_stable = state_ff.stable;
    cur = '0;
    prv = '0;
    trig = '0;
    fire_vec = '0;
    nxt_state = state_ff;
    nxt_state.s1 = cond_i;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    nxt_state.rail_mode = system_rail_mode_i;
    nxt_state.dbl_en = timer_double_en_i;
    // a change counts only once the second and third stages agree
    if (state_ff.s2 == state_ff.s3)
      nxt_stable = state_ff.s3;
    nxt_state.stable = nxt_stable;
    cur = level_vec(nxt_stable);
    prv = level_vec(state_ff.stable);
    trig = cur & ~prv;
    trig[`FLAG_PGOOD] = cur[`FLAG_PGOOD] ^ prv[`FLAG_PGOOD]; // see R1
    case (state_ff.start)
      ST_STARTUP:
      begin
        // the stages still hold reset zeros at first, so count them full before judging
        if (state_ff.fill != `SYNC_FILL)
          nxt_state.fill = state_ff.fill + 2'h1;
        else if (state_ff.s3 == state_ff.s2)
        begin
          if (state_ff.s3.ovp || state_ff.s3.ocp)
            nxt_state.start = ST_FAULT; // see R12
          else
            nxt_state.start = ST_RUN;
          nxt_state.pg_suppress = state_ff.s3.pgood && state_ff.s3.bat_uvlo; // see R2
        end
        trig = '0;
      end
      ST_FAULT:
        if (!nxt_stable.ovp && !nxt_stable.ocp)
          nxt_state.start = ST_RUN;
      ST_RUN: ;
      default: nxt_state.start = ST_STARTUP;
    endcase
    if (state_ff.start != ST_STARTUP)
    begin
      if (state_ff.pg_suppress && trig[`FLAG_PGOOD])
      begin
        trig[`FLAG_PGOOD] = 1'b0; // see R2
        nxt_state.pg_suppress = 1'b0;
      end
    end
    // read clears, but a new event in the same cycle keeps its flag
    if (flag_read_i)
      nxt_state.flags = '0; // see R13
    nxt_state.flags = nxt_state.flags | trig; // see R13
    fire_vec = trig & ~int_mask_i & ~state_ff.flags; // see R11
    if (state_ff.start != ST_RUN)
      fire_vec = '0; // see R12

    if (trig[`FLAG_DONE])
      nxt_state.done_hold = 1'b1; // see R7
    else if ((nxt_stable.pgood != state_ff.stable.pgood)
             || (nxt_stable.ce != state_ff.stable.ce)
             || nxt_stable.recharge)
      nxt_state.done_hold = 1'b0; // see R7

    nxt_state.ctrl.charge_en = nxt_stable.pgood && nxt_stable.ce // see R1
                               && !nxt_stable.ovp // see R4
                               && !nxt_stable.ocp // see R5
                               && !nxt_stable.cold // see R6
                               && !nxt_state.done_hold; // see R7
    nxt_state.ctrl.reduced_current = nxt_stable.ilim || nxt_stable.dppm // see R8
                                     || nxt_stable.vindpm || nxt_stable.therm; // see R9
    nxt_state.ctrl.timer_reset = !nxt_stable.pgood || nxt_stable.ovp // see R4
                                 || trig[`FLAG_DONE]; // see R7
    nxt_state.ctrl.timer_pause = nxt_stable.cold; // see R6
    nxt_state.ctrl.timer_double = timer_double_en_i && nxt_state.ctrl.reduced_current; // see R9
    nxt_state.ctrl.rail_from_input = nxt_stable.pgood && !nxt_stable.ovp // see R4
                                     && system_rail_mode_i == `RAIL_MODE_NORMAL; // see R3
    nxt_state.ctrl.rail_from_battery = !nxt_state.ctrl.rail_from_input && !nxt_stable.ocp;
    nxt_state.ctrl.battery_disconnect = nxt_stable.ocp; // see R5
  end

  assign fire = |fire_vec;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
      state_ff.ctrl <= `CTRL_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  int_pulse_gen u_pulse (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .fire_i(fire),
    .int_n_o(int_n_o),
    .int_oe_o(int_oe_o),
    .busy_o()
  );

  assign flags_o = state_ff.flags;
  assign ctrl_o = state_ff.ctrl;

  property p_pg_both_edges;
    @(posedge clk_i) disable iff (!rst_n)
    ($past(state_ff.start) != ST_STARTUP && $changed(state_ff.stable.pgood)
      && !$past(state_ff.pg_suppress)) |-> flags_o[`FLAG_PGOOD];
  endproperty
  a_pg_both_edges: assert property (p_pg_both_edges) else $error("pgood flag missed"); // see R1

  property p_pg_low_off;
    @(posedge clk_i) disable iff (!rst_n)
    !state_ff.stable.pgood |-> (!ctrl_o.charge_en && ctrl_o.timer_reset);
  endproperty
  a_pg_low_off: assert property (p_pg_low_off) else $error("charging with input bad"); // see R1

  property p_rail;
    @(posedge clk_i) disable iff (!rst_n)
    ctrl_o.rail_from_input |-> (state_ff.stable.pgood && state_ff.rail_mode == 2'h0);
  endproperty
  a_rail: assert property (p_rail) else $error("rail fed from input wrongly"); // see R3

  property p_ovp;
    @(posedge clk_i) disable iff (!rst_n)
    state_ff.stable.ovp |-> (!ctrl_o.charge_en && ctrl_o.timer_reset && !ctrl_o.rail_from_input);
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage response wrong"); // see R4

  property p_ocp;
    @(posedge clk_i) disable iff (!rst_n)
    state_ff.stable.ocp |-> (ctrl_o.battery_disconnect && !ctrl_o.charge_en);
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent response wrong"); // see R5

  property p_cold;
    @(posedge clk_i) disable iff (!rst_n)
    state_ff.stable.cold |-> (ctrl_o.timer_pause && !ctrl_o.charge_en);
  endproperty
  a_cold: assert property (p_cold) else $error("cold response wrong"); // see R6

  property p_done;
    @(posedge clk_i) disable iff (!rst_n)
    $rose(flags_o[`FLAG_DONE]) |-> (ctrl_o.timer_reset && !ctrl_o.charge_en);
  endproperty
  a_done: assert property (p_done) else $error("done response wrong"); // see R7

  property p_loops;
    @(posedge clk_i) disable iff (!rst_n)
    (state_ff.stable.ilim || state_ff.stable.therm) |->
      (ctrl_o.reduced_current && ctrl_o.timer_double == state_ff.dbl_en);
  endproperty
  a_loops: assert property (p_loops) else $error("loop response wrong"); // see R8

  property p_masked;
    @(posedge clk_i) disable iff (!rst_n)
    (fire_vec != '0) |-> ((fire_vec & int_mask_i) == '0);
  endproperty
  a_masked: assert property (p_masked) else $error("masked flag fired"); // see R11

  property p_no_int_unless_run;
    @(posedge clk_i) disable iff (!rst_n)
    (state_ff.start != ST_RUN) |=> !$rose(int_oe_o);
  endproperty
  a_no_int_unless_run: assert property (p_no_int_unless_run) else $error("early interrupt"); // see R12

  property p_latch;
    @(posedge clk_i) disable iff (!rst_n)
    (flags_o[`FLAG_OVP] && !flag_read_i) |=> flags_o[`FLAG_OVP];
  endproperty
  a_latch: assert property (p_latch) else $error("flag dropped without read"); // see R13

  c_ovp: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(flags_o[`FLAG_OVP]));
  c_fire: cover property (@(posedge clk_i) disable iff (!rst_n) fire);
  c_done_resume: cover property (@(posedge clk_i) disable iff (!rst_n) $fell(state_ff.done_hold));

endmodule : charger_fault_flag_response
`default_nettype wire

// file: rtl/int_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "charger_flag_consts.svh"

module int_pulse_gen
  import charger_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  output logic int_n_o,
  output logic int_oe_o,
  output logic busy_o
);
  typedef struct packed {
    logic [`INT_CNT_W-1:0] cnt;
    logic oe;
    logic pend;
  } pulse_s;

  pulse_s state_ff;
  pulse_s nxt_state;

  // a trigger during a pulse is held and sent after it; several triggers during one pulse merge into one
  always_comb
  begin
    nxt_state = state_ff;
    if (fire_i)
      nxt_state.pend = 1'b1;
    if (state_ff.oe)
    begin
      if (state_ff.cnt == `INT_CNT_W'(`INT_PULSE_CYC - 1))
      begin
        nxt_state.oe = 1'b0;
        nxt_state.cnt = '0;
      end
      else
        nxt_state.cnt = state_ff.cnt + `INT_CNT_W'(1);
    end
    else if (state_ff.pend || fire_i)
    begin
      nxt_state.oe = 1'b1;
      nxt_state.pend = 1'b0;
      nxt_state.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign int_n_o = 1'b0;
  assign int_oe_o = state_ff.oe; // see R10
  assign busy_o = state_ff.oe;

  property p_pulse_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(int_oe_o) |-> int_oe_o [*8] ##0 (state_ff.cnt == `INT_CNT_W'(7));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse shorter than expected"); // see R10

  property p_pulse_end;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(int_oe_o) |-> $past(state_ff.cnt) == `INT_CNT_W'(`INT_PULSE_CYC - 1);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse ended at wrong count"); // see R10

  c_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(int_oe_o));

endmodule : int_pulse_gen
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model
(
  input wire logic clk_i,
  input wire logic int_n_i,
  input wire logic int_oe_i,
  output logic flag_read_o,
  output int pulses_o,
  output int width_o
);
  logic line;
  int run;

  // the line has a pull-up, so a released pin reads high
  assign line = int_oe_i ? int_n_i : 1'b1;

  initial
  begin
    flag_read_o = 1'b0;
    pulses_o = 0;
    width_o = 0;
    run = 0;
  end

  // width is counted in whole clocks that the line was seen low; sampled on the
  // falling edge so the edge that moves the line never races the count
  always @(negedge clk_i)
  begin
    if (line === 1'b0)
      run <= run + 1;
    else if (run != 0)
    begin
      pulses_o <= pulses_o + 1;
      width_o <= run;
      run <= 0;
    end
  end

  // one-cycle read strobe, launched off the falling edge
  task read_flags();
    @(negedge clk_i) flag_read_o = 1'b1;
    @(negedge clk_i) flag_read_o = 1'b0;
  endtask : read_flags
endmodule : host_model

`default_nettype wire

// file: sim/tb_charger_fault_flag_response.sv
`timescale 1ns/100ps
`default_nettype none

module tb_charger_fault_flag_response;
  import charger_flag_pkg::*;
  logic clk, arst_n, dbl, rd, int_n, int_oe;
  logic [1:0] mode;
  cond_s cond;
  ctrl_s ctrl;
  flag_vec_t mask, flags;
  int pulses, width, bad_count, tests_run, cyc, p;

  charger_fault_flag_response charger_fault_flag_response_i (.clk_i(clk), .arst_n_i(arst_n),
    .cond_i(cond), .system_rail_mode_i(mode), .timer_double_en_i(dbl), .int_mask_i(mask),
    .flag_read_i(rd), .flags_o(flags), .ctrl_o(ctrl), .int_n_o(int_n), .int_oe_o(int_oe));
  host_model host_model_i (.clk_i(clk), .int_n_i(int_n), .int_oe_i(int_oe),
    .flag_read_o(rd), .pulses_o(pulses), .width_o(width));

  task close_out();
    $display("mismatches %0d comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task chk_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk_bit

  task chk_flags(input flag_vec_t got, input flag_vec_t exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t flags %h expected %h", $time, got, exp);
    end
  endtask : chk_flags

  task chk_num(input int got, input int exp, input string m);
    tests_run++;
    if (got != exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s %0d expected %0d", $time, m, got, exp);
    end
  endtask : chk_num

  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // flag k sits at condition bit 11-k
  task set_bit(input int k, input logic v);
    cond[11-k] = v;
  endtask : set_bit

  task do_reset();
    arst_n = 1'b0;
    wt(12);
    arst_n = 1'b1;
    wt(20);
  endtask : do_reset

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ceiling leaves room over the roughly 27000 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      close_out();
    end
  end

  initial
  begin
    cyc = 0;
    bad_count = 0;
    tests_run = 0;
    cond = '0;
    cond.pgood = 1'b1;
    cond.ce = 1'b1;
    mode = 2'h0;
    dbl = 1'b0;
    mask = '0;
    arst_n = 1'b0;
    do_reset();
    chk_num(pulses, 0, "start pulses");
    chk_bit(ctrl.rail_from_input, 1'b1, "rail input");
    mode = 2'h1;
    wt(3);
    chk_bit(ctrl.rail_from_input, 1'b0, "rail mode");
    mode = 2'h0;
    cond.ovp = 1'b1;
    wt(8);
    chk_flags(flags, 9'h002);
    chk_bit(ctrl.charge_en, 1'b0, "ovp charge");
    chk_bit(ctrl.timer_reset, 1'b1, "ovp timer");
    chk_bit(ctrl.rail_from_battery, 1'b1, "ovp rail");
    wt(3300);
    chk_num(pulses, 1, "ovp pulses");
    chk_num(width, 3200, "pulse width");
    cond.ovp = 1'b0;
    host_model_i.read_flags();
    wt(2);
    chk_flags(flags, 9'h000);
    mask = 9'h004;
    cond.ocp = 1'b1;
    wt(8);
    chk_flags(flags, 9'h004);
    chk_bit(ctrl.battery_disconnect, 1'b1, "ocp rail");
    chk_bit(ctrl.charge_en, 1'b0, "ocp charge");
    wt(3300);
    mask = 9'h000;
    wt(3300);
    chk_num(pulses, 1, "masked pulses");
    cond.ocp = 1'b0;
    host_model_i.read_flags();
    cond.pgood = 1'b0;
    wt(8);
    chk_flags(flags, 9'h001);
    chk_bit(ctrl.charge_en, 1'b0, "pgood low charge");
    chk_bit(ctrl.timer_reset, 1'b1, "pgood low timer");
    host_model_i.read_flags();
    cond.pgood = 1'b1;
    wt(8);
    chk_flags(flags, 9'h001);
    wt(6700);
    chk_num(pulses, 3, "pgood pulses");
    host_model_i.read_flags();
    mask = 9'h1ff;
    dbl = 1'b1;
    for (int k = 5; k <= 8; k++)
    begin
      set_bit(k, 1'b1);
      wt(8);
      chk_flags(flags, flag_vec_t'(9'h001 << k));
      chk_bit(ctrl.reduced_current, 1'b1, "loop current");
      chk_bit(ctrl.timer_double, 1'b1, "loop timer");
      chk_bit(ctrl.charge_en, 1'b1, "loop charge");
      set_bit(k, 1'b0);
      host_model_i.read_flags();
      wt(2);
    end
    cond.cold = 1'b1;
    wt(8);
    chk_flags(flags, 9'h008);
    chk_bit(ctrl.timer_pause, 1'b1, "cold timer");
    chk_bit(ctrl.charge_en, 1'b0, "cold charge");
    cond.cold = 1'b0;
    host_model_i.read_flags();
    cond.done = 1'b1;
    // the timer reset is a one-cycle strobe at the edge that latches the flag
    wt(4);
    chk_bit(ctrl.timer_reset, 1'b1, "done timer");
    wt(4);
    chk_flags(flags, 9'h010);
    cond.done = 1'b0;
    wt(8);
    chk_bit(ctrl.charge_en, 1'b0, "done held");
    cond.ce = 1'b0;
    wt(8);
    cond.ce = 1'b1;
    wt(8);
    chk_bit(ctrl.charge_en, 1'b1, "done resume");
    // battery under lockout at start: first power-good change stays silent
    cond.bat_uvlo = 1'b1;
    mask = 9'h000;
    do_reset();
    p = pulses;
    cond.pgood = 1'b0;
    wt(3300);
    chk_num(pulses, p, "uvlo start pulses");
    cond.pgood = 1'b1;
    wt(3300);
    chk_num(pulses, p + 1, "second pgood pulses");
    // starting into overvoltage: events before the fault clears send nothing
    cond.ovp = 1'b1;
    do_reset();
    p = pulses;
    cond.cold = 1'b1;
    wt(3300);
    chk_num(pulses, p, "fault start pulses");
    chk_flags(flags, 9'h008);
    close_out();
  end
endmodule : tb_charger_fault_flag_response

`default_nettype wire
